//--- common/mtt_pkg.sv
// Package with register map, field layout and reset values of the tick timer
package mtt_pkg;
  // Register byte offsets
  localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CLOCK_CONFIG   = 4'h4;
  localparam logic [3:0] ADDR_CURRENT_TALLY  = 4'h8;
  localparam logic [3:0] ADDR_WRAP_VALUE     = 4'hC;
  // Status and control field positions
  localparam int OVF_FLAG_BIT  = 7;
  localparam int OVF_IRQ_EN_BIT = 6;
  localparam int CLEAR_CMD_BIT = 5;
  localparam int HALT_BIT      = 4;
  // Clock configuration field positions
  localparam int SRC_SEL_LSB   = 4;
  localparam int PS_SEL_LSB    = 0;
  // Reset values
  localparam logic [7:0] WRAP_RESET  = 8'h00;
  localparam logic [7:0] TALLY_RESET = 8'h00;
  localparam logic [1:0] SRC_RESET   = 2'h0;
  localparam logic [3:0] PS_RESET    = 4'h0;
  localparam logic       HALT_RESET  = 1'b1;
  // Source select encodings
  localparam logic [1:0] SRC_BUS     = 2'h0;
  localparam logic [1:0] SRC_FIXED   = 2'h1;
  localparam logic [1:0] SRC_PIN_FALL = 2'h2;
  localparam logic [1:0] SRC_PIN_RISE = 2'h3;
  // Highest defined prescale code, divides by 256
  localparam logic [3:0] PS_MAX_CODE = 4'h8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- core/mtt_prescaler.sv
// Prescaler: 8-bit divider chain with selectable tap
`timescale 1ns/10ps
module mtt_prescaler
  import mtt_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             src_tick,
  input  wire logic             run,
  input  wire logic [3:0]       ps_sel,
  output logic                  cnt_tick
);
  logic [WIDTH-1:0] div_ff;
  logic [WIDTH-1:0] nxt_div;
  logic [3:0]       tap;
  logic             hit;

  // Undefined codes fall back to the longest ratio
  always_comb begin
    tap = (ps_sel > PS_MAX_CODE) ? PS_MAX_CODE : ps_sel;  // [R20]
    nxt_div = div_ff;
    hit = 1'b0;
    if (run && src_tick) begin
      nxt_div = div_ff + 1'b1;  // [R25]
      // A tick passes when the low tap bits are all ones
      if (tap == 4'h0) begin
        hit = 1'b1;
      end else begin
        hit = &(div_ff | ~((WIDTH'(1) << tap) - WIDTH'(1)));  // [R9]
      end
    end
  end

  // Chain keeps its phase across ratio changes, count is untouched
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;  // [R10]
    end
  end

  assign cnt_tick = hit;
endmodule

//--- core/mtt_timer.sv
// Modulo tick timer with AXI4-Lite register slave
// Notes on behaviour
// R1: Wrap value write zeroes count, clears flag
// R2: Wrap value resets to zero
// R3: Zero wrap value means free-running
// R4: Modes stopped, free-running, wrap
// R5: Reset: halted, zero, bus clock, divide one
// R6: Software clears halt to start counting
// R7: Four sources: bus, fixed, pin edges
// R8: Source change keeps count
// R9: Nine ratios 1 to 256
// R10: Ratio change keeps count
// R11: Wrap value accepts 1 through 255
// R12: Count to wrap value, then roll over
// R13: Flag sets on wrap-to-zero transition
// R14: Clear flag by read then write zero
// R15: Overflow between steps cancels clearing
// R16: Clear command or wrap write clears flag
// R17: Interrupt when flag and enable set
// R18: Software clears flag before enabling interrupt
// R19: Source codes 00 bus,01 fixed,10 fall,11 rise
// R20: Undefined prescale codes divide by 256
// R21: Clear command zeroes count, reads zero
// R22: Halt holds count, reset sets halt
// R23: Free-running rolls 255 to zero, flags
// R24: Pin synchronised, edges become single enables
// R25: Prescaler is 8-bit divider chain
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
module mtt_timer
  import mtt_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        fixed_rate_clock,
  input  wire logic        external_tick_pin,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             overflow_irq
);
  // Bus write channel state
  logic        aw_ff,   nxt_aw;
  logic [3:0]  awa_ff,  nxt_awa;
  logic        w_ff,    nxt_w;
  logic [31:0] wd_ff,   nxt_wd;
  logic [3:0]  ws_ff,   nxt_ws;
  logic        bv_ff,   nxt_bv;
  logic [1:0]  br_ff,   nxt_br;
  // Bus read channel state
  logic        rv_ff,   nxt_rv;
  logic [31:0] rd_ff,   nxt_rd;
  logic [1:0]  rr_ff,   nxt_rr;
  // Registered readies, so no gate sits between a flop and a pin
  logic        awrdy_ff, nxt_awrdy;
  logic        wrdy_ff,  nxt_wrdy;
  logic        arrdy_ff, nxt_arrdy;
  // Timer state
  logic [7:0]  tally_ff,  nxt_tally;
  logic [7:0]  wrap_ff,   nxt_wrap;
  logic        ovf_ff,    nxt_ovf;
  logic        armed_ff,  nxt_armed;
  logic        ie_ff,     nxt_ie;
  logic        halt_ff,   nxt_halt;
  logic [1:0]  src_ff,    nxt_src;
  logic [3:0]  ps_ff,     nxt_ps;
  logic        irq_ff,    nxt_irq;
  // Input synchronisers and edge history
  logic        pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic        fix_s1_ff, fix_s2_ff, fix_s3_ff;
  // Combinational helpers
  logic        do_wr, do_rd, wr_ok, rd_ok;
  logic        src_tick, cnt_tick, roll;
  logic [7:0]  wb;
  logic [31:0] rdv;

  // Source edge selection from synchronised inputs
  always_comb begin
    unique case (src_ff)  // [R7] [R19]
      SRC_BUS:      src_tick = 1'b1;
      SRC_FIXED:    src_tick = fix_s2_ff & ~fix_s3_ff;
      SRC_PIN_FALL: src_tick = ~pin_s2_ff & pin_s3_ff;  // [R24]
      SRC_PIN_RISE: src_tick = pin_s2_ff & ~pin_s3_ff;  // [R24]
    endcase
  end

  // Source changes only redirect ticks, the tally is untouched
  mtt_prescaler #(.WIDTH(8)) u_prescaler (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .src_tick (src_tick),
    .run      (~halt_ff),
    .ps_sel   (ps_ff),
    .cnt_tick (cnt_tick)
  );

  // Write is done once both address and data are held
  always_comb begin
    do_wr = aw_ff && w_ff && !bv_ff;
    wr_ok = (awa_ff[1:0] == 2'h0);
    wb    = ws_ff[0] ? wd_ff[7:0] : 8'h00;
    do_rd = s_axi_arvalid && s_axi_arready;
    rd_ok = (s_axi_araddr[1:0] == 2'h0);
    // Roll when count meets wrap value, 255 when free-running
    roll  = cnt_tick && !halt_ff &&
            ((wrap_ff == 8'h00) ? (tally_ff == 8'hFF)  // [R3] [R23]
                                : (tally_ff == wrap_ff));  // [R11] [R12]
  end

  // Bus channel handshakes
  always_comb begin
    nxt_aw  = aw_ff;
    nxt_awa = awa_ff;
    nxt_w   = w_ff;
    nxt_wd  = wd_ff;
    nxt_ws  = ws_ff;
    nxt_bv  = bv_ff;
    nxt_br  = br_ff;
    nxt_rv  = rv_ff;
    nxt_rd  = rd_ff;
    nxt_rr  = rr_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw  = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w  = 1'b1;
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
    end
    if (do_wr) begin
      nxt_aw = 1'b0;
      nxt_w  = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    if (do_rd) begin
      nxt_rv = 1'b1;
      nxt_rd = rdv;
      nxt_rr = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
    // Readies stay low until the answer is taken: one transfer at a time
    nxt_awrdy = !nxt_aw && !nxt_bv;
    nxt_wrdy  = !nxt_w && !nxt_bv;
    nxt_arrdy = !nxt_rv;
  end

  // Read data; the clear command bit always reads zero
  always_comb begin
    rdv = 32'h0000_0000;
    unique case (s_axi_araddr)
      ADDR_STATUS_CONTROL: begin
        rdv[OVF_FLAG_BIT]   = ovf_ff;
        rdv[OVF_IRQ_EN_BIT] = ie_ff;
        rdv[HALT_BIT]       = halt_ff;  // [R21]
      end
      ADDR_CLOCK_CONFIG: begin
        rdv[SRC_SEL_LSB +: 2] = src_ff;
        rdv[PS_SEL_LSB +: 4]  = ps_ff;
      end
      ADDR_CURRENT_TALLY: rdv[7:0] = tally_ff;
      ADDR_WRAP_VALUE:    rdv[7:0] = wrap_ff;
      default:            rdv = 32'h0000_0000;
    endcase
  end

  // Timer control, counting and flag handling
  always_comb begin
    nxt_tally = tally_ff;
    nxt_wrap  = wrap_ff;
    nxt_ovf   = ovf_ff;
    nxt_armed = armed_ff;
    nxt_ie    = ie_ff;
    nxt_halt  = halt_ff;
    nxt_src   = src_ff;
    nxt_ps    = ps_ff;
    // Halted counter holds its value
    if (!halt_ff && cnt_tick) begin  // [R4] [R22]
      nxt_tally = roll ? 8'h00 : tally_ff + 8'h01;  // [R12]
    end
    // A read that sees the flag set arms the two-step clear
    if (do_rd && rd_ok && s_axi_araddr == ADDR_STATUS_CONTROL && ovf_ff) begin
      nxt_armed = 1'b1;  // [R14]
    end
    if (do_wr && wr_ok && ws_ff[0]) begin
      unique case (awa_ff)
        ADDR_STATUS_CONTROL: begin
          nxt_ie   = wb[OVF_IRQ_EN_BIT];
          nxt_halt = wb[HALT_BIT];  // [R6] [R22]
          if (!wb[OVF_FLAG_BIT] && armed_ff) begin
            nxt_ovf   = 1'b0;  // [R14]
            nxt_armed = 1'b0;
          end
          if (wb[CLEAR_CMD_BIT]) begin
            nxt_tally = TALLY_RESET;  // [R21]
            nxt_ovf   = 1'b0;  // [R16]
            nxt_armed = 1'b0;
          end
        end
        ADDR_CLOCK_CONFIG: begin
          nxt_src = wb[SRC_SEL_LSB +: 2];  // [R8]
          nxt_ps  = wb[PS_SEL_LSB +: 4];  // [R10]
        end
        ADDR_WRAP_VALUE: begin
          nxt_wrap  = wb;  // [R11]
          nxt_tally = TALLY_RESET;  // [R1]
          nxt_ovf   = 1'b0;  // [R1] [R16]
          nxt_armed = 1'b0;
        end
        default: begin
          nxt_wrap = wrap_ff;
        end
      endcase
    end
    // A new overflow disarms the clear and wins over any clear
    if (roll) begin
      nxt_ovf   = 1'b1;  // [R13]
      nxt_armed = 1'b0;  // [R15]
    end
    // Enabling with the flag set fires at once; software avoids it
    nxt_irq = nxt_ovf && nxt_ie;  // [R17] [R18]
  end

  // Synchronisers: first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
      fix_s1_ff <= 1'b0;
      fix_s2_ff <= 1'b0;
      fix_s3_ff <= 1'b0;
    end else begin
      pin_s1_ff <= external_tick_pin;  // [R24]
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      fix_s1_ff <= fixed_rate_clock;
      fix_s2_ff <= fix_s1_ff;
      fix_s3_ff <= fix_s2_ff;
    end
  end

  // State registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_ff    <= 1'b0;
      awa_ff   <= 4'h0;
      w_ff     <= 1'b0;
      wd_ff    <= 32'h0000_0000;
      ws_ff    <= 4'h0;
      bv_ff    <= 1'b0;
      br_ff    <= RESP_OKAY;
      rv_ff    <= 1'b0;
      rd_ff    <= 32'h0000_0000;
      rr_ff    <= RESP_OKAY;
      awrdy_ff <= 1'b1;
      wrdy_ff  <= 1'b1;
      arrdy_ff <= 1'b1;
      tally_ff <= TALLY_RESET;  // [R5]
      wrap_ff  <= WRAP_RESET;  // [R2]
      ovf_ff   <= 1'b0;
      armed_ff <= 1'b0;
      ie_ff    <= 1'b0;
      halt_ff  <= HALT_RESET;  // [R5] [R22]
      src_ff   <= SRC_RESET;  // [R5]
      ps_ff    <= PS_RESET;  // [R5]
      irq_ff   <= 1'b0;
    end else begin
      aw_ff    <= nxt_aw;
      awa_ff   <= nxt_awa;
      w_ff     <= nxt_w;
      wd_ff    <= nxt_wd;
      ws_ff    <= nxt_ws;
      bv_ff    <= nxt_bv;
      br_ff    <= nxt_br;
      rv_ff    <= nxt_rv;
      rd_ff    <= nxt_rd;
      rr_ff    <= nxt_rr;
      awrdy_ff <= nxt_awrdy;
      wrdy_ff  <= nxt_wrdy;
      arrdy_ff <= nxt_arrdy;
      tally_ff <= nxt_tally;
      wrap_ff  <= nxt_wrap;
      ovf_ff   <= nxt_ovf;
      armed_ff <= nxt_armed;
      ie_ff    <= nxt_ie;
      halt_ff  <= nxt_halt;
      src_ff   <= nxt_src;
      ps_ff    <= nxt_ps;
      irq_ff   <= nxt_irq;
    end
  end

  // Every output comes straight from a register
  assign s_axi_awready = awrdy_ff;
  assign s_axi_wready  = wrdy_ff;
  assign s_axi_bvalid  = bv_ff;
  assign s_axi_bresp   = br_ff;
  assign s_axi_arready = arrdy_ff;
  assign s_axi_rvalid  = rv_ff;
  assign s_axi_rdata   = rd_ff;
  assign s_axi_rresp   = rr_ff;
  assign overflow_irq  = irq_ff;
endmodule

//--- testbench/mtt_timer_monitor.sv
// Checker of bus handshakes and read fields of the tick timer
`timescale 1ns/10ps
module mtt_timer_monitor
  import mtt_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        overflow_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Response arrives two edges after a joint address and data hand-off
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not on time");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready) else $error("write taken while answer pending");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data not one edge after address");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  // Misaligned offsets must be refused with an error response
  a_read_error: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == RESP_SLVERR)
    else $error("misaligned read not refused");
  a_ctrl_zero: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATUS_CONTROL
    |=> s_axi_rdata[5] == 1'b0 && s_axi_rdata[3:0] == 4'h0)
    else $error("clear command or unused bits read nonzero");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] ==
    24'h000000) else $error("upper read bits nonzero");
  c_irq: cover property (overflow_irq);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

//--- testbench/mtt_timer_test.sv
// Self-checking bench for the tick timer over its register bus
`timescale 1ns/10ps
module mtt_timer_test;
  import mtt_pkg::*;
  logic        sys_clk, rst_b = 1'b0, fixed_rate_clock = 1'b0;
  logic        external_tick_pin = 1'b0, s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, overflow_irq;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
  int          num_errors = 0, compares = 0;
  mtt_timer u_mtt_timer (.sys_clk, .rst_b, .fixed_rate_clock,
    .external_tick_pin, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .overflow_irq);
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One byte write; the extra edge keeps bready from toggling in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  // Slow fixed-rate pulses, well under half the bus clock
  task automatic pul(input int n);
    repeat (n) begin
      fixed_rate_clock <= 1'b1;
      repeat (2) @(posedge sys_clk);
      fixed_rate_clock <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
  // Pin change, then room for the synchroniser latency
  task automatic pin(input logic v);
    external_tick_pin <= v;
    repeat (6) @(posedge sys_clk);
  endtask
  // Hang guard, far above the expected run of about 7000 cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rc(ADDR_STATUS_CONTROL, 32'h00000010);
    rc(ADDR_CLOCK_CONFIG, 32'h00000000);
    rc(ADDR_CURRENT_TALLY, 32'h00000000);
    rc(ADDR_WRAP_VALUE, 32'h00000000);
    chk(32'(last_resp), 32'(RESP_OKAY));
    rd(4'h2);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    wr(4'h6, 8'hFF);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    rc(ADDR_STATUS_CONTROL, 32'h00000010);
    $display("test reset done");
    // Every ratio code: two increments per two division periods
    wr(ADDR_CLOCK_CONFIG, 8'h10);
    wr(ADDR_STATUS_CONTROL, 8'h00);
    for (int k = 0; k < 10; k++) begin
      wr(ADDR_CLOCK_CONFIG, 8'h10 | 8'(k));
      pul(k > 8 ? 512 : 2 << k);
      repeat (6) @(posedge sys_clk);
      rc(ADDR_CURRENT_TALLY, 32'(8'(2 * k + 2)));
    end
    $display("test prescale done");
    wr(ADDR_CLOCK_CONFIG, 8'h30);
    pin(1'b1);
    rc(ADDR_CURRENT_TALLY, 32'h00000015);
    wr(ADDR_CLOCK_CONFIG, 8'h20);
    pin(1'b0);
    pin(1'b1);
    rc(ADDR_CURRENT_TALLY, 32'h00000016);
    $display("test sources done");
    // Wrap at 3 on the bus clock overflows every four edges
    wr(ADDR_CLOCK_CONFIG, 8'h00);
    wr(ADDR_WRAP_VALUE, 8'h03);
    repeat (10) @(posedge sys_clk);
    rc(ADDR_STATUS_CONTROL, 32'h00000080);
    wr(ADDR_STATUS_CONTROL, 8'h00);
    rc(ADDR_STATUS_CONTROL, 32'h00000080);
    wr(ADDR_STATUS_CONTROL, 8'h10);
    rd(ADDR_CURRENT_TALLY);
    chk(32'(d > 32'h3), 32'h0);
    wr(ADDR_STATUS_CONTROL, 8'h10);
    rc(ADDR_STATUS_CONTROL, 32'h00000090);
    wr(ADDR_STATUS_CONTROL, 8'h10);
    rc(ADDR_STATUS_CONTROL, 32'h00000010);
    $display("test flag clear done");
    wr(ADDR_STATUS_CONTROL, 8'h40);
    repeat (10) @(posedge sys_clk);
    chk(32'(overflow_irq), 32'h1);
    wr(ADDR_STATUS_CONTROL, 8'h50);
    wr(ADDR_STATUS_CONTROL, 8'hF0);
    rc(ADDR_STATUS_CONTROL, 32'h00000050);
    rc(ADDR_CURRENT_TALLY, 32'h00000000);
    chk(32'(overflow_irq), 32'h0);
    wr(ADDR_CURRENT_TALLY, 8'h55);
    chk(32'(last_resp), 32'(RESP_OKAY));
    rc(ADDR_CURRENT_TALLY, 32'h00000000);
    wr(ADDR_STATUS_CONTROL, 8'h40);
    repeat (10) @(posedge sys_clk);
    wr(ADDR_STATUS_CONTROL, 8'h50);
    wr(ADDR_WRAP_VALUE, 8'h05);
    rc(ADDR_STATUS_CONTROL, 32'h00000050);
    rc(ADDR_CURRENT_TALLY, 32'h00000000);
    rc(ADDR_WRAP_VALUE, 32'h00000005);
    // A write without its low byte lane must leave the register alone
    s_axi_wstrb <= 4'hE;
    wr(ADDR_WRAP_VALUE, 8'h07);
    s_axi_wstrb <= 4'hF;
    rc(ADDR_WRAP_VALUE, 32'h00000005);
    $display("test irq done");
    // Zero wrap value runs past 5 and rolls only after 255
    wr(ADDR_WRAP_VALUE, 8'h00);
    wr(ADDR_STATUS_CONTROL, 8'h00);
    repeat (200) @(posedge sys_clk);
    wr(ADDR_STATUS_CONTROL, 8'h10);
    rd(ADDR_CURRENT_TALLY);
    chk(32'(d > 32'h5), 32'h1);
    rc(ADDR_STATUS_CONTROL, 32'h00000010);
    wr(ADDR_STATUS_CONTROL, 8'h00);
    repeat (100) @(posedge sys_clk);
    wr(ADDR_STATUS_CONTROL, 8'h10);
    rc(ADDR_STATUS_CONTROL, 32'h00000090);
    $display("test free run done");
    print_verdict();
  end
endmodule
bind mtt_timer mtt_timer_monitor u_mtt_timer_monitor (.sys_clk, .rst_b,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .overflow_irq);
